// ---- src/rcp_pkg.sv ----
// Shared constants and types for the serial command port.
// Assumes a single 200 MHz clock and a plain register port.
`default_nettype none

package rcp_pkg;

  // ***************************************************************
  // Clock and bit timing
  // ***************************************************************
  localparam int unsigned SYS_CLK_HZ  = 200_000_000;
  localparam int unsigned OVS_RATE    = 16;
  localparam int unsigned BAUD_MIN    = 300;
  // Every selectable rate is the slowest one times a power of two
  localparam int unsigned OVS_DIV_300 = SYS_CLK_HZ / (OVS_RATE * BAUD_MIN);
  localparam int          DIV_W       = 17;
  localparam logic [3:0]  OVS_LAST    = 4'hf;
  localparam logic [3:0]  OVS_MID     = 4'h7;

  // ***************************************************************
  // Register map and fields
  // ***************************************************************
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_MASK   = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA = 8'h0c;
  localparam logic [7:0]  ADDR_RXDATA = 8'h10;
  localparam logic [7:0]  ADDR_PROMPT = 8'h14;
  localparam logic [7:0]  ADDR_LINE   = 8'h18;

  localparam int          CTRL_W      = 10;
  // Rate 9600, no parity, 8 data, 1 stop, talk only off, header on
  localparam logic [9:0]  CTRL_RST    = 10'h105;
  localparam logic [2:0]  BAUD_SEL_MAX = 3'h6;
  localparam logic [1:0]  PAR_NONE    = 2'h0;
  localparam logic [1:0]  PAR_EVEN    = 2'h1;
  localparam logic [1:0]  PAR_ODD     = 2'h2;
  localparam int          PROMPT_ERR_BIT = 0;

  // Sticky event bits of the status and mask registers
  localparam int ST_RX_CHAR  = 0;
  localparam int ST_CMD_END  = 1;
  localparam int ST_CMD_LONG = 2;
  localparam int ST_PAR_ERR  = 3;
  localparam int ST_FRM_ERR  = 4;
  localparam int ST_TX_DONE  = 5;
  localparam int ST_W        = 6;

  // ***************************************************************
  // Characters and command limits
  // ***************************************************************
  localparam logic [7:0]  CHAR_CR     = 8'h0d;
  localparam logic [7:0]  CHAR_LF     = 8'h0a;
  localparam logic [7:0]  CHAR_OK     = 8'h3d;
  localparam logic [7:0]  CHAR_ERR    = 8'h3f;
  localparam logic [7:0]  CHAR_GT     = 8'h3e;
  localparam logic [2:0]  PROMPT_LAST = 3'h4;
  localparam logic [7:0]  MAX_CMD_LEN = 8'hfb;
  localparam logic [2:0]  LAST_BIT_7  = 3'h6;
  localparam logic [2:0]  LAST_BIT_8  = 3'h7;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } rcp_bus_req_t;

  typedef struct packed {
    logic       port_sel;
    logic       hdr_on;
    logic       talk_only;
    logic       stop2;
    logic       data7;
    logic [1:0] parity;
    logic [2:0] baud;
  } rcp_ctrl_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    rcp_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    rcp_rx_st_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } rcp_div_state_t;

  typedef struct packed {
    rcp_ctrl_t        ctrl;
    logic [ST_W-1:0]  mask;
    logic [ST_W-1:0]  status;
    logic [31:0]      rd_data;
    logic             irq;
    logic             txd;
    rcp_tx_st_t       tx_st;
    logic [7:0]       tx_shift;
    logic             tx_par;
    logic [2:0]       tx_bit;
    logic [3:0]       tx_ovs;
    logic             tx_stop_more;
    logic [7:0]       hold;
    logic             hold_v;
    logic             pr_act;
    logic             pr_err;
    logic [2:0]       pr_idx;
    rcp_rx_st_t       rx_st;
    logic [7:0]       rx_shift;
    logic             rx_par;
    logic [2:0]       rx_bit;
    logic [3:0]       rx_ovs;
    logic [7:0]       rx_data;
    logic [7:0]       cmd_len;
    logic             cmd_long;
  } rcp_state_t;

endpackage

`default_nettype wire

// ---- src/rcp_sync2.sv ----
// Two-stage synchroniser for pins that arrive from outside the clock.
// Assumes the inputs are plain levels; the first stage feeds stage two only.
`default_nettype none

module rcp_sync2 #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } rcp_sync_state_t;

  rcp_sync_state_t s_r;
  rcp_sync_state_t s_nxt;

  // ***************************************************************
  // Stages
  // ***************************************************************
  // Stage one is only ever read by stage two
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = din;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= {RST, RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.sync;

endmodule

`default_nettype wire

// ---- src/rcp_tick_div.sv ----
// Oversample tick divider: one-cycle enable every period clocks.
// Assumes period is at least 2 and stable while en is high.
`default_nettype none

module rcp_tick_div
  import rcp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             en,
  input  wire logic [DIV_W-1:0] period,
  output logic                  tick
);

  rcp_div_state_t s_r;
  rcp_div_state_t s_nxt;

  // ***************************************************************
  // Down counter
  // ***************************************************************
  // Held at zero while off so a new rate starts cleanly
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!en) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == '0) begin
      s_nxt.cnt  = period - 1'b1;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule

`default_nettype wire

// ---- src/rcp_serial_port.sv ----
// Serial command port: UART framing, command length check, prompt sender.
// Assumes one 200 MHz clock, a one-cycle register port, raw line pins.
//
// Operation
// - Line rate is one of 300 to 19200 baud in doubling steps, 9600 at reset.
// - Parity is none, even or odd, none at reset, used both ways.
// - Characters carry 7 or 8 data bits, 8 at reset.
// - One or two stop bits end each frame, one at reset.
// - One response-header switch, on at reset, is shared with the USB port.
// - A new character leaves only while the data-set-ready input is true.
// - Commands hold at most 251 characters; a longer one raises an error.
// - XON and XOFF are plain data; the ready input is the only throttle.
// - The port works only while it is the selected remote interface.
// - Each command is answered with an OK prompt or a distinct error prompt.
`default_nettype none

module rcp_serial_port
  import rcp_pkg::*;
#(
  parameter int unsigned OVS_DIV_SLOW = OVS_DIV_300
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire rcp_bus_req_t bus,
  output logic [31:0]       rd_data,
  input  wire logic         rxd,
  input  wire logic         dsr,
  output logic              txd,
  output logic              dtr,
  output logic              irq,
  output logic              header_on
);

  rcp_state_t       s_r;
  rcp_state_t       s_nxt;
  logic [1:0]       pins_s;
  logic             rxd_s;
  logic             dsr_s;
  logic             tick;
  logic [2:0]       baud_sel;
  logic [DIV_W-1:0] period;

  // ***************************************************************
  // Pins, rate and oversample tick
  // ***************************************************************
  // Idle line reads high, so the receiver sees no false start
  rcp_sync2 #(
    .W   (2),
    .RST (2'h2)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({rxd, dsr}),
    .dout    (pins_s)
  );

  assign rxd_s = pins_s[1];
  assign dsr_s = pins_s[0];

  // Rates double per step, so one shift gives each divisor
  assign baud_sel = (s_r.ctrl.baud > BAUD_SEL_MAX) ? BAUD_SEL_MAX :
                    s_r.ctrl.baud;
  assign period   = DIV_W'(OVS_DIV_SLOW >> baud_sel);

  // Divider runs on after deselection until a frame in flight has ended,
  // so the line is never left parked low in the middle of a character
  rcp_tick_div u_div (
    .sys_clk (sys_clk),
    .reset   (reset),
    .en      (s_r.ctrl.port_sel || (s_r.tx_st != TX_IDLE)),
    .period  (period),
    .tick    (tick)
  );

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Prompt line: LF, marker, '>', CR, LF
  function automatic logic [7:0] prompt_char(input logic [2:0] idx,
                                             input logic       err);
    logic [7:0] c;
    c = CHAR_LF;
    case (idx)
      3'h1: begin
        c = err ? CHAR_ERR : CHAR_OK;
      end
      3'h2: begin
        c = CHAR_GT;
      end
      3'h3: begin
        c = CHAR_CR;
      end
      default: begin
        c = CHAR_LF;
      end
    endcase
    return c;
  endfunction

  // Parity bit for the configured width and sense
  function automatic logic par_bit(input logic [7:0] d,
                                   input rcp_ctrl_t  c);
    logic p;
    p = c.data7 ? ^d[6:0] : ^d;
    return (c.parity == PAR_ODD) ? ~p : p;
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic [ST_W-1:0] ev;
    logic [2:0]      last_bit;
    logic [7:0]      rx_byte;
    logic            use_par;
    logic            rx_on;
    ev       = '0;
    last_bit = s_r.ctrl.data7 ? LAST_BIT_7 : LAST_BIT_8;
    rx_byte  = s_r.ctrl.data7 ? {1'b0, s_r.rx_shift[7:1]} : s_r.rx_shift;
    use_par  = (s_r.ctrl.parity == PAR_EVEN) ||
               (s_r.ctrl.parity == PAR_ODD);
    rx_on    = s_r.ctrl.port_sel && !s_r.ctrl.talk_only;
    s_nxt    = s_r;

    // Register writes; data for the line lands only when there is room
    if (bus.we) begin
      case (bus.addr)
        ADDR_CTRL: begin
          s_nxt.ctrl = rcp_ctrl_t'(bus.wdata[CTRL_W-1:0]);
        end
        ADDR_MASK: begin
          s_nxt.mask = bus.wdata[ST_W-1:0];
        end
        ADDR_TXDATA: begin
          if (!s_r.hold_v && !s_r.pr_act && s_r.ctrl.port_sel) begin
            s_nxt.hold   = bus.wdata[7:0];
            s_nxt.hold_v = 1'b1;
          end
        end
        ADDR_PROMPT: begin
          if (!s_r.pr_act && s_r.ctrl.port_sel) begin
            s_nxt.pr_act = 1'b1;
            s_nxt.pr_err = bus.wdata[PROMPT_ERR_BIT];
            s_nxt.pr_idx = '0;
          end
        end
        default: begin
        end
      endcase
    end

    // Prompt sequencer feeds the holding byte one character at a time
    if (s_r.pr_act && !s_r.hold_v) begin
      s_nxt.hold   = prompt_char(s_r.pr_idx, s_r.pr_err);
      s_nxt.hold_v = 1'b1;
      s_nxt.pr_idx = s_r.pr_idx + 1'b1;
      if (s_r.pr_idx == PROMPT_LAST) begin
        s_nxt.pr_act = 1'b0;
      end
    end

    // Transmitter, stepped by the oversample tick
    if (tick) begin
      s_nxt.tx_ovs = s_r.tx_ovs + 1'b1;
      case (s_r.tx_st)
        TX_IDLE: begin
          s_nxt.txd    = 1'b1;
          s_nxt.tx_ovs = '0;
          // Finished frames are never cut; only new ones wait
          if (s_r.hold_v && dsr_s && s_r.ctrl.port_sel) begin
            s_nxt.tx_shift = s_r.hold;
            s_nxt.tx_par   = par_bit(s_r.hold, s_r.ctrl);
            s_nxt.hold_v   = 1'b0;
            s_nxt.txd      = 1'b0;
            s_nxt.tx_st    = TX_START;
          end
        end
        TX_START: begin
          if (s_r.tx_ovs == OVS_LAST) begin
            s_nxt.txd    = s_r.tx_shift[0];
            s_nxt.tx_bit = '0;
            s_nxt.tx_st  = TX_DATA;
          end
        end
        TX_DATA: begin
          if (s_r.tx_ovs == OVS_LAST) begin
            s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
            s_nxt.tx_bit   = s_r.tx_bit + 1'b1;
            s_nxt.txd      = s_r.tx_shift[1];
            if (s_r.tx_bit == last_bit) begin
              s_nxt.tx_stop_more = s_r.ctrl.stop2;
              if (use_par) begin
                s_nxt.txd   = s_r.tx_par;
                s_nxt.tx_st = TX_PAR;
              end else begin
                s_nxt.txd   = 1'b1;
                s_nxt.tx_st = TX_STOP;
              end
            end
          end
        end
        TX_PAR: begin
          if (s_r.tx_ovs == OVS_LAST) begin
            s_nxt.txd   = 1'b1;
            s_nxt.tx_st = TX_STOP;
          end
        end
        TX_STOP: begin
          if (s_r.tx_ovs == OVS_LAST) begin
            if (s_r.tx_stop_more) begin
              s_nxt.tx_stop_more = 1'b0;
            end else begin
              s_nxt.tx_st      = TX_IDLE;
              ev[ST_TX_DONE]   = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.tx_st = TX_IDLE;
          s_nxt.txd   = 1'b1;
        end
      endcase
    end

    // Receiver: start checked mid-bit, data sampled at bit centres
    if (tick) begin
      s_nxt.rx_ovs = s_r.rx_ovs + 1'b1;
      case (s_r.rx_st)
        RX_IDLE: begin
          s_nxt.rx_ovs = '0;
          if (rx_on && !rxd_s) begin
            s_nxt.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (s_r.rx_ovs == OVS_MID) begin
            s_nxt.rx_ovs = '0;
            s_nxt.rx_bit = '0;
            // A glitch shorter than half a bit is dropped here
            s_nxt.rx_st  = rxd_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (s_r.rx_ovs == OVS_LAST) begin
            s_nxt.rx_shift = {rxd_s, s_r.rx_shift[7:1]};
            s_nxt.rx_bit   = s_r.rx_bit + 1'b1;
            if (s_r.rx_bit == last_bit) begin
              s_nxt.rx_st = use_par ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (s_r.rx_ovs == OVS_LAST) begin
            s_nxt.rx_par = rxd_s;
            s_nxt.rx_st  = RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is checked, as usual for receivers
          if (s_r.rx_ovs == OVS_LAST) begin
            s_nxt.rx_st    = RX_IDLE;
            s_nxt.rx_data  = rx_byte;
            ev[ST_RX_CHAR] = 1'b1;
            ev[ST_FRM_ERR] = !rxd_s;
            ev[ST_PAR_ERR] = use_par &&
              (s_r.rx_par != par_bit(rx_byte, s_r.ctrl));
            // XON and XOFF fall through as ordinary characters
            if (rx_byte == CHAR_CR) begin
              ev[ST_CMD_END] = 1'b1;
              s_nxt.cmd_len  = '0;
              s_nxt.cmd_long = 1'b0;
            end else if (s_r.cmd_len == MAX_CMD_LEN) begin
              ev[ST_CMD_LONG] = !s_r.cmd_long;
              s_nxt.cmd_long  = 1'b1;
            end else begin
              s_nxt.cmd_len = s_r.cmd_len + 1'b1;
            end
          end
        end
        default: begin
          s_nxt.rx_st = RX_IDLE;
        end
      endcase
    end

    // Register reads answer one cycle later; status clears on read
    s_nxt.rd_data = '0;
    if (bus.re) begin
      case (bus.addr)
        ADDR_CTRL: begin
          s_nxt.rd_data = {22'h0, s_r.ctrl};
        end
        ADDR_STATUS: begin
          s_nxt.rd_data = {26'h0, s_r.status};
          s_nxt.status  = '0;
        end
        ADDR_MASK: begin
          s_nxt.rd_data = {26'h0, s_r.mask};
        end
        ADDR_RXDATA: begin
          s_nxt.rd_data = {24'h0, s_r.rx_data};
        end
        ADDR_LINE: begin
          s_nxt.rd_data = {18'h0, s_r.cmd_long, dsr_s,
                           (s_r.rx_st != RX_IDLE), (s_r.tx_st != TX_IDLE),
                           s_r.pr_act, s_r.hold_v, s_r.cmd_len};
        end
        default: begin
          s_nxt.rd_data = '0;
        end
      endcase
    end

    // New events win over a clear in the same cycle
    s_nxt.status = s_nxt.status | ev;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r      <= '0;
      s_r.ctrl <= rcp_ctrl_t'(CTRL_RST);
      s_r.txd  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state flops
  assign rd_data   = s_r.rd_data;
  assign txd       = s_r.txd;
  assign dtr       = s_r.ctrl.port_sel;
  assign irq       = s_r.irq;
  assign header_on = s_r.ctrl.hdr_on;

endmodule

`default_nettype wire

// ---- verif/rcp_port_chk.sv ----
// Assertions on the serial command port pins and register port.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module rcp_port_chk
  import rcp_pkg::*;
#(
  parameter int unsigned OVS_DIV_SLOW = OVS_DIV_300
) (
  input wire logic         sys_clk,
  input wire logic         reset,
  input wire rcp_bus_req_t bus,
  input wire logic [31:0]  rd_data,
  input wire logic         txd,
  input wire logic         dtr,
  input wire logic         irq,
  input wire logic         header_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // Helper state
  // ***************************************************************
  // Longest low run: start, eight data and parity at the slowest rate
  localparam int LOW_MAX = 160 * OVS_DIV_SLOW + 8;
  logic [9:0] sh_r;
  int         lo_r;
  int         ds_r;
  int         ds_lim;

  // Control shadow plus run counters for a low line and a quiet port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sh_r <= CTRL_RST;
      lo_r <= 0;
      ds_r <= 0;
    end else begin
      if (bus.we && bus.addr == ADDR_CTRL) begin
        sh_r <= bus.wdata[9:0];
      end
      lo_r <= txd ? 0 : lo_r + 1;
      ds_r <= dtr ? 0 : ds_r + 1;
    end
  end

  // A frame in flight at deselection may finish, nothing after it
  assign ds_lim = 192 * int'(OVS_DIV_SLOW >>
    ((sh_r[2:0] > BAUD_SEL_MAX) ? BAUD_SEL_MAX : sh_r[2:0])) + 8;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  ctrl_readback_a:
    assert property (bus.re && bus.addr == ADDR_CTRL |=>
      rd_data == {22'h0, $past(sh_r)}) else $error("control readback wrong");
  hdr_shared_a:
    assert property ($past(sh_r) == sh_r && $past(sh_r, 2) == sh_r |->
      header_on == sh_r[8]) else $error("header output off setting");
  port_sel_a:
    assert property ($past(sh_r) == sh_r && $past(sh_r, 2) == sh_r |->
      dtr == sh_r[9]) else $error("select output off setting");
  rd_idle_a:
    assert property (!$past(bus.re) |-> rd_data == 32'h0)
    else $error("read data outside read slot");
  irq_masked_a:
    assert property (bus.we && bus.addr == ADDR_MASK && bus.wdata[5:0] == 6'h0
      ##1 !(bus.we && bus.addr == ADDR_MASK) |=> !irq)
    else $error("interrupt with all sources masked");
  reset_idle_a:
    assert property ($fell(reset) |-> txd && !dtr && !irq && header_on &&
      rd_data == 32'h0) else $error("pins not at rest after reset");
  low_run_a:
    assert property (lo_r <= LOW_MAX) else $error("line low too long");
  desel_quiet_a:
    assert property (ds_r >= ds_lim |-> txd)
    else $error("transmit while deselected");

  cover property (irq && bus.re && bus.addr == ADDR_STATUS);
  cover property ($fell(txd));
  cover property ($rose(dtr));
endmodule

bind rcp_serial_port rcp_port_chk #(.OVS_DIV_SLOW(OVS_DIV_SLOW)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .bus(bus), .rd_data(rd_data),
  .txd(txd), .dtr(dtr), .irq(irq), .header_on(header_on));

`default_nettype wire

// ---- verif/rcp_host_model.sv ----
// Host side of the serial link: sends and receives framed characters.
// Assumes the bench sets bclk and the frame format before traffic.
`default_nettype none

module rcp_host_model
  import rcp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      dsr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // Frame format and captured characters
  // ***************************************************************
  int         bclk = 32;
  logic       data7 = 1'b0;
  logic       stop2 = 1'b0;
  logic [1:0] par = PAR_NONE;
  logic       frm_bad = 1'b0;
  logic [7:0] rxq[$];

  // Line at mark and ready true until the bench says otherwise
  initial begin
    rxd = 1'b1;
    dsr = 1'b1;
  end

  function automatic logic par_of(input logic [7:0] d);
    logic [7:0] m;
    m = data7 ? {1'b0, d[6:0]} : d;
    return (par == PAR_ODD) ? ~^m : ^m;
  endfunction

  // One bit for a whole bit time, changed only at an edge
  task automatic put_bit(input logic b);
    rxd <= b;
    repeat (bclk) @(posedge sys_clk);
  endtask

  // Frame out; flip spoils the parity bit on purpose
  task automatic send(input logic [7:0] d, input logic flip);
    put_bit(1'b0);
    for (int i = 0; i < (data7 ? 7 : 8); i++)
      put_bit(d[i]);
    if (par != PAR_NONE)
      put_bit(par_of(d) ^ flip);
    put_bit(1'b1);
    if (stop2)
      put_bit(1'b1);
  endtask

  // Frame in: sample mid-bit, note bad parity or a missing stop bit
  always begin : rx_side
    logic [7:0] d;
    @(negedge txd);
    d = 8'h00;
    repeat (bclk / 2) @(posedge sys_clk);
    for (int i = 0; i < (data7 ? 7 : 8); i++) begin
      repeat (bclk) @(posedge sys_clk);
      d[i] = txd;
    end
    if (par != PAR_NONE) begin
      repeat (bclk) @(posedge sys_clk);
      frm_bad = frm_bad | (txd !== par_of(d));
    end
    for (int i = 0; i < (stop2 ? 2 : 1); i++) begin
      repeat (bclk) @(posedge sys_clk);
      frm_bad = frm_bad | (txd !== 1'b1);
    end
    rxq.push_back(d);
  end
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the serial command port and a host model.
// Assumes the checker file binds itself to the port.
`default_nettype none

module tb_top
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Small divider keeps the slow rates short, tick stays two clocks
  localparam int unsigned OVS = 128;
  logic         sys_clk;
  logic         reset;
  rcp_bus_req_t bus;
  logic [31:0]  rd_data;
  logic         rxd, dsr, txd, dtr, irq, header_on;
  logic [31:0]  v;
  logic [9:0]   w;
  int           bad_count = 0;
  int           n_checks = 0;

  rcp_serial_port #(.OVS_DIV_SLOW(OVS)) uut (
    .sys_clk(sys_clk), .reset(reset), .bus(bus), .rd_data(rd_data),
    .rxd(rxd), .dsr(dsr), .txd(txd), .dtr(dtr), .irq(irq),
    .header_on(header_on));
  rcp_host_model u_host (
    .sys_clk(sys_clk), .txd(txd), .rxd(rxd), .dsr(dsr));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus cycles wait an edge first, so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk) bus <= '0;
    @(posedge sys_clk) d = rd_data;
  endtask

  // Control word to the port, same format to the host
  task automatic cfg(input logic [9:0] c);
    wr(ADDR_CTRL, {22'h0, c});
    u_host.bclk = 16 * int'(OVS >> c[2:0]);
    u_host.par = c[4:3];
    u_host.data7 = c[5];
    u_host.stop2 = c[6];
  endtask

  task automatic tx_get(input logic [7:0] e);
    for (int i = 0; i < 14 * u_host.bclk && u_host.rxq.size() == 0; i++)
      @(posedge sys_clk);
    v = (u_host.rxq.size() != 0) ? u_host.rxq.pop_front() : 32'hdead;
    chk(v, {24'h0, e});
  endtask

  task automatic t_reset();
    rd(ADDR_CTRL, v);
    chk(v, {22'h0, CTRL_RST});
    chk({31'h0, dtr}, 32'h0);
    rd(8'h1c, v);
    chk(v, 32'h0);
  endtask

  // Every rate read back, a character sent at 1200 baud and up; XON and XOFF go out as plain data
  task automatic t_tx();
    for (int b = 0; b < 7; b++) begin
      w = {2'h3, 1'b0, b[1], b[0], 2'(b % 3), 3'(b)};
      cfg(w);
      rd(ADDR_CTRL, v);
      chk(v, {22'h0, w});
      if (b >= 2) begin
        wr(ADDR_TXDATA, b[0] ? 32'h13 : 32'h11);
        tx_get(b[0] ? 8'h13 : 8'h11);
        chk({31'h0, u_host.frm_bad}, 32'h0);
      end
    end
  endtask

  // Words: even 8 bits 1 stop, odd 7 bits 2 stops, both at the top rate
  task automatic t_rx();
    cfg(10'h30e);
    rd(ADDR_STATUS, v);
    u_host.send(8'ha5, 1'b0);
    rd(ADDR_RXDATA, v);
    chk(v, 32'ha5);
    rd(ADDR_STATUS, v);
    chk(v[3:0], 4'h1);
    u_host.send(8'h3c, 1'b1);
    rd(ADDR_STATUS, v);
    chk(v[3], 1'b1);
    cfg(10'h376);
    u_host.send(8'hff, 1'b0);
    rd(ADDR_RXDATA, v);
    chk(v, 32'h7f);
    rd(ADDR_STATUS, v);
    chk(v[4:0], 5'h01);
  endtask

  task automatic t_dsr();
    cfg(10'h306);
    u_host.dsr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(ADDR_TXDATA, 32'h55);
    repeat (960) @(posedge sys_clk);
    chk(32'(u_host.rxq.size()), 32'h0);
    u_host.dsr <= 1'b1;
    tx_get(8'h55);
    repeat (32) @(posedge sys_clk);
    rd(ADDR_STATUS, v);
    chk(v[5], 1'b1);
  endtask

  task automatic t_prompt();
    logic [7:0] ok [5];
    ok = '{CHAR_LF, CHAR_OK, CHAR_GT, CHAR_CR, CHAR_LF};
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_PROMPT, 32'(e));
      for (int i = 0; i < 5; i++)
        tx_get((i == 1 && e == 1) ? CHAR_ERR : ok[i]);
      // Let the last stop bit end before the next prompt
      repeat (64) @(posedge sys_clk);
    end
  endtask

  // Command of 251 then 252 characters, long flag drives the interrupt
  task automatic t_long();
    cfg(10'h326);
    u_host.send(CHAR_CR, 1'b0);
    rd(ADDR_STATUS, v);
    wr(ADDR_MASK, 32'h1 << ST_CMD_LONG);
    for (int i = 0; i < 251; i++)
      u_host.send(8'h41, 1'b0);
    rd(ADDR_LINE, v);
    chk({v[13], v[7:0]}, {1'b0, MAX_CMD_LEN});
    chk({31'h0, irq}, 32'h0);
    u_host.send(8'h41, 1'b0);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_STATUS, v);
    chk(v[2:0], 3'h5);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    u_host.send(CHAR_CR, 1'b0);
    rd(ADDR_STATUS, v);
    chk(v[2:1], 2'h1);
    rd(ADDR_LINE, v);
    chk(v[7:0], 8'h00);
    wr(ADDR_MASK, 32'h0);
  endtask

  task automatic t_talk();
    cfg(10'h386);
    rd(ADDR_STATUS, v);
    u_host.send(8'h42, 1'b0);
    rd(ADDR_STATUS, v);
    chk(v[0], 1'b0);
  endtask

  // A frame in flight ends after deselection; then no traffic either way
  task automatic t_desel();
    wr(ADDR_TXDATA, 32'h3a);
    repeat (64) @(posedge sys_clk);
    wr(ADDR_CTRL, 32'h006);
    @(posedge sys_clk);
    chk({30'h0, header_on, dtr}, 32'h0);
    wr(ADDR_TXDATA, 32'h5a);
    tx_get(8'h3a);
    u_host.send(8'h42, 1'b0);
    rd(ADDR_STATUS, v);
    chk(v[0], 1'b0);
    repeat (512) @(posedge sys_clk);
    chk(32'(u_host.rxq.size()), 32'h0);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    bus = '0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_dsr();
    t_prompt();
    t_long();
    t_talk();
    t_desel();
    finish_test();
  end

  // Hang guard, just past the expected run of some 92k cycles
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule

`default_nettype wire
